//--- dus_pkg.sv
package dus_pkg;
    // Register byte offsets within one channel, channel B adds the stride
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_MCTRL = 8'h04;
    localparam logic [7:0] OFS_FEAT = 8'h08;
    localparam logic [7:0] OFS_IEN = 8'h0c;
    localparam logic [7:0] OFS_MSTAT = 8'h10;
    localparam logic [7:0] OFS_LSTAT = 8'h14;
    localparam logic [7:0] OFS_ISTAT = 8'h18;
    localparam logic [7:0] OFS_IMASK = 8'h1c;
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [7:0] MAP_END = 8'h40;
    localparam int CH_BIT = 5;
    // Modem control fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_IRQ_OE = 3;
    localparam int MC_IR = 6;
    // Feature and interrupt-enable fields
    localparam int FE_AUTO_RTS = 6;
    localparam int FE_AUTO_CTS = 7;
    localparam int IE_RTS = 6;
    localparam int IE_CTS = 7;
    // Modem status fields, active high copies of the pins
    localparam int MS_CTS = 4;
    localparam int MS_DSR = 5;
    localparam int MS_RI = 6;
    localparam int MS_CD = 7;
    // Line status fields
    localparam int LS_RX_VALID = 0;
    localparam int LS_OVERRUN = 1;
    localparam int LS_THR_EMPTY = 5;
    localparam int LS_TX_IDLE = 6;
    // Interrupt status and mask fields
    localparam int IS_RX = 0;
    localparam int IS_TX = 1;
    localparam int IS_OVERRUN = 2;
    localparam int IS_MODEM = 3;
    // Reset values
    localparam logic [7:0] MCTRL_RST = 8'h00;
    localparam logic [7:0] FEAT_RST = 8'h00;
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [7:0] IMASK_RST = 8'h00;
    // Timing
    localparam longint CLK_HZ = 10000000;
    localparam longint BAUD = 115200;
    localparam int BIT_CYCLES = int'(CLK_HZ / BAUD);
    localparam int IR_PULSE_NUM = 3;
    localparam int IR_PULSE_DEN = 16;
    localparam int RESET_MIN_NS = 40;
    localparam int RESET_CYCLES = int'((RESET_MIN_NS * CLK_HZ + 999999999) / 1000000000);
    localparam int CNT_W = 16;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} dus_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dus_rx_state_t;

    typedef struct packed {
        logic ri_n;
        logic cd_n;
        logic dsr_n;
        logic cts_n;
    } dus_modem_in_t;

    typedef struct packed {
        logic irq_lvl;
        logic irq_oe_n;
        logic aux2_n;
        logic rts_n;
        logic dtr_n;
        logic ser_out;
    } dus_pins_out_t;
endpackage

//--- dus_dual_serial.sv
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module dus_dual_serial #(
    parameter int BIT_CYCLES = dus_pkg::BIT_CYCLES
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in_ch_a,
    output logic serial_out_ch_a,
    output logic request_to_send_n_ch_a,
    input wire logic clear_to_send_n_ch_a,
    output logic terminal_ready_n_ch_a,
    input wire logic set_ready_n_ch_a,
    input wire logic carrier_detect_n_ch_a,
    input wire logic ring_indicate_n_ch_a,
    output logic aux_out2_n_ch_a,
    output logic irq_out_ch_a,
    output logic irq_out_oe_n_ch_a,
    input wire logic serial_in_ch_b,
    output logic serial_out_ch_b,
    output logic request_to_send_n_ch_b,
    input wire logic clear_to_send_n_ch_b,
    output logic terminal_ready_n_ch_b,
    input wire logic set_ready_n_ch_b,
    input wire logic carrier_detect_n_ch_b,
    input wire logic ring_indicate_n_ch_b,
    output logic aux_out2_n_ch_b,
    output logic irq_out_ch_b,
    output logic irq_out_oe_n_ch_b,
    output logic rx_ready_n_ch_b
);
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);
    localparam logic [15:0] IR_CYC =
        16'((BIT_CYCLES * dus_pkg::IR_PULSE_NUM) / dus_pkg::IR_PULSE_DEN);

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = addr[dus_pkg::CH_BIT-1:0] == ofs[dus_pkg::CH_BIT-1:0];
    endfunction

    function automatic logic [31:0] word(input logic [7:0] v);
        word = {24'h000000, v};
    endfunction

    logic addr_ok;
    logic access;
    logic [31:0] rd_val [2];
    logic ser_in [2];
    dus_pkg::dus_modem_in_t modem_in [2];
    dus_pkg::dus_pins_out_t pins [2];
    logic rx_valid_ch [2];

    assign addr_ok = (paddr < dus_pkg::MAP_END) && (paddr[1:0] == 2'h0);
    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && !addr_ok;

    assign ser_in[0] = serial_in_ch_a;
    assign ser_in[1] = serial_in_ch_b;
    assign modem_in[0] = '{ri_n: ring_indicate_n_ch_a, cd_n: carrier_detect_n_ch_a,
                           dsr_n: set_ready_n_ch_a, cts_n: clear_to_send_n_ch_a};
    assign modem_in[1] = '{ri_n: ring_indicate_n_ch_b, cd_n: carrier_detect_n_ch_b,
                           dsr_n: set_ready_n_ch_b, cts_n: clear_to_send_n_ch_b};

    assign serial_out_ch_a = pins[0].ser_out;
    assign terminal_ready_n_ch_a = pins[0].dtr_n;
    assign request_to_send_n_ch_a = pins[0].rts_n;
    assign aux_out2_n_ch_a = pins[0].aux2_n;
    assign irq_out_oe_n_ch_a = pins[0].irq_oe_n;
    assign irq_out_ch_a = pins[0].irq_lvl;
    assign serial_out_ch_b = pins[1].ser_out;
    assign terminal_ready_n_ch_b = pins[1].dtr_n;
    assign request_to_send_n_ch_b = pins[1].rts_n;
    assign aux_out2_n_ch_b = pins[1].aux2_n;
    assign irq_out_oe_n_ch_b = pins[1].irq_oe_n;
    assign irq_out_ch_b = pins[1].irq_lvl;

    // Read data captured in the setup cycle, zero wait states
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= addr_ok ? rd_val[paddr[dus_pkg::CH_BIT]] : 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rx_ready_n_ch_b <= 1'b1;
        end else begin
            rx_ready_n_ch_b <= !rx_valid_ch[1];
        end
    end

    for (genvar g = 0; g < 2; g++) begin : chan
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] mctrl;
        logic [7:0] feat;
        logic [7:0] ien;
        logic [7:0] istat;
        logic [7:0] imask;
        logic [7:0] thr;
        logic thr_full;
        logic [7:0] rx_holding_reg;
        logic rx_valid;
        dus_pkg::dus_tx_state_t tx_st;
        logic [15:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tsr;
        logic tx_line;
        logic tx_take;
        logic cts_hold;
        dus_pkg::dus_rx_state_t rx_st;
        logic [15:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rsr;
        logic rx_done;
        logic [15:0] ir_stretch;
        logic rx_line;
        dus_pkg::dus_modem_in_t modem_q;
        logic [7:0] events;
        logic [7:0] mstat;
        logic [7:0] lstat;

        assign sel = addr_ok && (paddr[dus_pkg::CH_BIT] == 1'(g));
        assign wr = access && pwrite && sel;
        assign rd = access && !pwrite && sel;

        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                mctrl <= dus_pkg::MCTRL_RST;
                feat <= dus_pkg::FEAT_RST;
                ien <= dus_pkg::IEN_RST;
                imask <= dus_pkg::IMASK_RST;
            end else if (wr) begin
                if (reg_hit(paddr, dus_pkg::OFS_MCTRL)) begin
                    mctrl <= pwdata[7:0];
                end
                if (reg_hit(paddr, dus_pkg::OFS_FEAT)) begin
                    feat <= pwdata[7:0];
                end
                if (reg_hit(paddr, dus_pkg::OFS_IEN)) begin
                    ien <= pwdata[7:0];
                end
                if (reg_hit(paddr, dus_pkg::OFS_IMASK)) begin
                    imask <= pwdata[7:0];
                end
            end
        end

        assign cts_hold = feat[dus_pkg::FE_AUTO_CTS] && ien[dus_pkg::IE_CTS]
                          && modem_in[g].cts_n;
        assign tx_take = (tx_st == dus_pkg::TX_IDLE) && thr_full && !cts_hold;

        // Transmit holding register, writes ignored while full
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                thr <= 8'h00;
                thr_full <= 1'b0;
            end else if (wr && reg_hit(paddr, dus_pkg::OFS_DATA) && !thr_full) begin
                thr <= pwdata[7:0];
                thr_full <= 1'b1;
            end else if (tx_take) begin
                thr_full <= 1'b0;
            end
        end

        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                tx_st <= dus_pkg::TX_IDLE;
                tx_cnt <= 16'h0000;
                tx_bit <= 3'h0;
                tsr <= 8'h00;
                tx_line <= 1'b1;
            end else begin
                tx_cnt <= (tx_cnt == BIT_LAST) ? 16'h0000 : tx_cnt + 16'h0001;
                case (tx_st)
                    dus_pkg::TX_IDLE: begin
                        tx_line <= 1'b1;
                        tx_cnt <= 16'h0000;
                        if (tx_take) begin
                            tsr <= thr;
                            tx_line <= 1'b0;
                            tx_st <= dus_pkg::TX_START;
                        end
                    end
                    dus_pkg::TX_START: begin
                        if (tx_cnt == BIT_LAST) begin
                            tx_bit <= 3'h0;
                            tx_line <= tsr[0];
                            tx_st <= dus_pkg::TX_DATA;
                        end
                    end
                    dus_pkg::TX_DATA: begin
                        if (tx_cnt == BIT_LAST) begin
                            if (tx_bit == 3'h7) begin
                                tx_line <= 1'b1;
                                tx_st <= dus_pkg::TX_STOP;
                            end else begin
                                tx_bit <= tx_bit + 3'h1;
                                tx_line <= tsr[tx_bit + 3'h1];
                            end
                        end
                    end
                    dus_pkg::TX_STOP: begin
                        if (tx_cnt == BIT_LAST) begin
                            tx_st <= dus_pkg::TX_IDLE;
                        end
                    end
                    default: begin
                        tx_st <= dus_pkg::TX_IDLE;
                    end
                endcase
            end
        end

        // infrared pulses stretched back to one bit time
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                ir_stretch <= 16'h0000;
            end else if (ser_in[g]) begin
                ir_stretch <= BIT_LAST;
            end else if (ir_stretch != 16'h0000) begin
                ir_stretch <= ir_stretch - 16'h0001;
            end
        end

        assign rx_line = mctrl[dus_pkg::MC_IR] ? (ir_stretch == 16'h0000 && !ser_in[g])
                                               : ser_in[g];

        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                rx_st <= dus_pkg::RX_IDLE;
                rx_cnt <= 16'h0000;
                rx_bit <= 3'h0;
                rsr <= 8'h00;
                rx_done <= 1'b0;
            end else begin
                rx_done <= 1'b0;
                rx_cnt <= (rx_cnt == BIT_LAST) ? 16'h0000 : rx_cnt + 16'h0001;
                case (rx_st)
                    dus_pkg::RX_IDLE: begin
                        rx_cnt <= 16'h0000;
                        if (!rx_line) begin
                            rx_st <= dus_pkg::RX_START;
                        end
                    end
                    dus_pkg::RX_START: begin
                        if (rx_cnt == BIT_HALF) begin
                            rx_cnt <= 16'h0000;
                            rx_bit <= 3'h0;
                            rx_st <= rx_line ? dus_pkg::RX_IDLE : dus_pkg::RX_DATA;
                        end
                    end
                    dus_pkg::RX_DATA: begin
                        if (rx_cnt == BIT_LAST) begin
                            rsr[rx_bit] <= rx_line;
                            rx_bit <= rx_bit + 3'h1;
                            if (rx_bit == 3'h7) begin
                                rx_st <= dus_pkg::RX_STOP;
                            end
                        end
                    end
                    dus_pkg::RX_STOP: begin
                        if (rx_cnt == BIT_LAST) begin
                            rx_done <= rx_line;
                            rx_st <= dus_pkg::RX_IDLE;
                        end
                    end
                    default: begin
                        rx_st <= dus_pkg::RX_IDLE;
                    end
                endcase
            end
        end

        // Receive holding register, new data wins over the read
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                rx_holding_reg <= 8'h00;
                rx_valid <= 1'b0;
            end else if (rx_done) begin
                rx_holding_reg <= rsr;
                rx_valid <= 1'b1;
            end else if (rd && reg_hit(paddr, dus_pkg::OFS_DATA)) begin
                rx_valid <= 1'b0;
            end
        end
        assign rx_valid_ch[g] = rx_valid;

        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                modem_q <= '1;
            end else begin
                modem_q <= modem_in[g];
            end
        end

        always_comb begin
            events = 8'h00;
            events[dus_pkg::IS_RX] = rx_done;
            events[dus_pkg::IS_TX] = tx_take;
            events[dus_pkg::IS_OVERRUN] = rx_done && rx_valid;
            events[dus_pkg::IS_MODEM] = modem_q != modem_in[g];
        end

        // Sticky status, write one to clear, set wins
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                istat <= 8'h00;
            end else if (wr && reg_hit(paddr, dus_pkg::OFS_ISTAT)) begin
                istat <= (istat & ~pwdata[7:0]) | events;
            end else begin
                istat <= istat | events;
            end
        end

        always_comb begin
            mstat = 8'h00;
            mstat[dus_pkg::MS_CTS] = !modem_in[g].cts_n;
            mstat[dus_pkg::MS_DSR] = !modem_in[g].dsr_n;
            mstat[dus_pkg::MS_RI] = !modem_in[g].ri_n;
            mstat[dus_pkg::MS_CD] = !modem_in[g].cd_n;
            lstat = 8'h00;
            lstat[dus_pkg::LS_RX_VALID] = rx_valid;
            lstat[dus_pkg::LS_OVERRUN] = istat[dus_pkg::IS_OVERRUN];
            lstat[dus_pkg::LS_THR_EMPTY] = !thr_full;
            lstat[dus_pkg::LS_TX_IDLE] = !thr_full && (tx_st == dus_pkg::TX_IDLE);
        end

        always_comb begin
            rd_val[g] = 32'h00000000;
            case (paddr[dus_pkg::CH_BIT-1:0])
                dus_pkg::OFS_DATA[4:0]: rd_val[g] = word(rx_holding_reg);
                dus_pkg::OFS_MCTRL[4:0]: rd_val[g] = word(mctrl);
                dus_pkg::OFS_FEAT[4:0]: rd_val[g] = word(feat);
                dus_pkg::OFS_IEN[4:0]: rd_val[g] = word(ien);
                dus_pkg::OFS_MSTAT[4:0]: rd_val[g] = word(mstat);
                dus_pkg::OFS_LSTAT[4:0]: rd_val[g] = word(lstat);
                dus_pkg::OFS_ISTAT[4:0]: rd_val[g] = word(istat);
                dus_pkg::OFS_IMASK[4:0]: rd_val[g] = word(imask);
                default: rd_val[g] = 32'h00000000;
            endcase
        end

        // Pin drivers; set-ready, carrier and ring only reach mstat and the modem bit of istat
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                pins[g] <= '{irq_lvl: 1'b0, irq_oe_n: 1'b1, aux2_n: 1'b1,
                             rts_n: 1'b1, dtr_n: 1'b1, ser_out: 1'b1};
            end else begin
                // infrared pulse on zero bits, low otherwise
                pins[g].ser_out <= mctrl[dus_pkg::MC_IR] ? (!tx_line && tx_cnt < IR_CYC)
                                                         : tx_line;
                pins[g].dtr_n <= !mctrl[dus_pkg::MC_DTR];
                // automatic release only while request bit is set
                pins[g].rts_n <= !(mctrl[dus_pkg::MC_RTS] && !(feat[dus_pkg::FE_AUTO_RTS]
                                   && ien[dus_pkg::IE_RTS] && rx_valid));
                pins[g].irq_oe_n <= !mctrl[dus_pkg::MC_IRQ_OE];
                pins[g].aux2_n <= !mctrl[dus_pkg::MC_IRQ_OE];
                // output-port-2 has no separate software control
                pins[g].irq_lvl <= |(istat & imask);
            end
        end
    end
endmodule

//--- dus_dual_serial_assertions.sv
`timescale 1ns/1ps
module dus_dual_serial_checker #(
    parameter int BIT_CYCLES = dus_pkg::BIT_CYCLES
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_out_ch_a,
    input wire logic terminal_ready_n_ch_a,
    input wire logic aux_out2_n_ch_a,
    input wire logic irq_out_ch_a,
    input wire logic irq_out_oe_n_ch_a,
    input wire logic aux_out2_n_ch_b,
    input wire logic irq_out_oe_n_ch_b,
    input wire logic rx_ready_n_ch_b
);
    logic [31:0] wd_q;
    int low_run;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Last control word written to channel a
    always_ff @(posedge mclk) begin
        if (psel && penable && pwrite && paddr == dus_pkg::OFS_MCTRL) begin
            wd_q <= pwdata;
        end
    end
    always_ff @(posedge mclk) begin
        if (!reset_n || serial_out_ch_a) begin
            low_run <= 0;
        end else begin
            low_run <= low_run + 1;
        end
    end
    AST_AUX_IRQ_A: assert property (aux_out2_n_ch_a == irq_out_oe_n_ch_a)
        else $error("aux2 and irq enable differ on channel a");
    AST_AUX_IRQ_B: assert property (aux_out2_n_ch_b == irq_out_oe_n_ch_b)
        else $error("aux2 and irq enable differ on channel b");
    AST_RESET_VALUES: assert property ($rose(reset_n) |-> serial_out_ch_a &&
        aux_out2_n_ch_a && irq_out_oe_n_ch_a && !irq_out_ch_a && rx_ready_n_ch_b)
        else $error("outputs not at reset levels");
    AST_MCTRL_A: assert property (psel && penable && pwrite && paddr == dus_pkg::OFS_MCTRL
        |-> ##2 terminal_ready_n_ch_a == !wd_q[0] && aux_out2_n_ch_a == !wd_q[3])
        else $error("control pins do not follow write");
    AST_UNMAPPED: assert property (psel && penable && paddr >= dus_pkg::MAP_END |-> pslverr)
        else $error("no error on unmapped access");
    AST_READY: assert property (psel && penable |-> pready)
        else $error("ready low in access phase");
    AST_RX_READ_B: assert property (psel && penable && !pwrite &&
        paddr == dus_pkg::CH_STRIDE |-> ##[1:2] rx_ready_n_ch_b)
        else $error("receiver ready stays low after read");
    AST_START_LEN_A: assert property ($fell(serial_out_ch_a) |-> !serial_out_ch_a[*8])
        else $error("start bit too short");
    AST_LOW_RUN_A: assert property (low_run <= 9 * BIT_CYCLES)
        else $error("transmit line low too long");
    cover property (!rx_ready_n_ch_b);
    cover property ($fell(serial_out_ch_a));
    cover property (psel && penable && pslverr);
endmodule
bind dus_dual_serial dus_dual_serial_checker #(.BIT_CYCLES(BIT_CYCLES)) dus_dual_serial_checker_i (
    .mclk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
    .serial_out_ch_a, .terminal_ready_n_ch_a, .aux_out2_n_ch_a, .irq_out_ch_a,
    .irq_out_oe_n_ch_a, .aux_out2_n_ch_b, .irq_out_oe_n_ch_b, .rx_ready_n_ch_b);

//--- dus_remote_model.sv
`timescale 1ns/1ps
module dus_remote_model #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic mclk,
    input wire logic line_in,
    output logic line_out,
    output dus_pkg::dus_modem_in_t modem
);
    initial begin
        line_out = 1'h1;
        modem = '1;
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            line_out <= f[i];
            repeat (BIT_CYCLES - 1) @(posedge mclk);
        end
    endtask
    // infrared: line idles low, one short pulse per zero bit
    task automatic send_ir(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        line_out <= 1'h0;
        repeat (12 * BIT_CYCLES) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            line_out <= !f[i];
            @(posedge mclk);
            line_out <= 1'h0;
            repeat (BIT_CYCLES - 2) @(posedge mclk);
        end
    endtask
    task automatic grab(output logic [7:0] b);
        @(posedge mclk iff !line_in);
        repeat (BIT_CYCLES / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge mclk);
            b[i] = line_in;
        end
    endtask
endmodule

//--- dus_dual_serial_tb.sv
`timescale 1ns/1ps
module dus_dual_serial_tb;
    localparam int BC = 8;
    localparam logic [7:0] B = dus_pkg::CH_STRIDE;
    logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic serial_in_ch_a, serial_out_ch_a, request_to_send_n_ch_a, terminal_ready_n_ch_a;
    logic aux_out2_n_ch_a, irq_out_ch_a, irq_out_oe_n_ch_a, serial_in_ch_b, serial_out_ch_b;
    logic request_to_send_n_ch_b, terminal_ready_n_ch_b, aux_out2_n_ch_b, irq_out_ch_b;
    logic irq_out_oe_n_ch_b, rx_ready_n_ch_b;
    dus_pkg::dus_modem_in_t mod_a, mod_b;
    int bad_count = 0, num_checks = 0;
    wire irq_pin_b = irq_out_oe_n_ch_b ? 1'hz : irq_out_ch_b;
    wire clear_to_send_n_ch_a = mod_a.cts_n, set_ready_n_ch_a = mod_a.dsr_n;
    wire carrier_detect_n_ch_a = mod_a.cd_n, ring_indicate_n_ch_a = mod_a.ri_n;
    wire clear_to_send_n_ch_b = mod_b.cts_n, set_ready_n_ch_b = mod_b.dsr_n;
    wire carrier_detect_n_ch_b = mod_b.cd_n, ring_indicate_n_ch_b = mod_b.ri_n;
    dus_dual_serial #(.BIT_CYCLES(BC)) dus_dual_serial_i (.*);
    dus_remote_model #(.BIT_CYCLES(BC)) model_a (.mclk(mclk), .line_in(serial_out_ch_a),
        .line_out(serial_in_ch_a), .modem(mod_a));
    dus_remote_model #(.BIT_CYCLES(BC)) model_b (.mclk(mclk), .line_in(serial_out_ch_b),
        .line_out(serial_in_ch_b), .modem(mod_b));
    always #50 mclk = ~mclk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'h1;
        @(posedge mclk);
        penable <= 1'h1;
        @(posedge mclk iff pready === 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic t_reset;
        chk("reset pins", 32'h7f, {serial_out_ch_a, serial_out_ch_b, aux_out2_n_ch_a,
            aux_out2_n_ch_b, irq_out_oe_n_ch_a, terminal_ready_n_ch_a, rx_ready_n_ch_b});
        apb(dus_pkg::OFS_MCTRL, 1'h0, 32'h0);
        chk("control reset", {24'h0, dus_pkg::MCTRL_RST}, rdat);
    endtask
    task automatic t_ctrl;
        apb(dus_pkg::OFS_MCTRL, 1'h1, 32'h0b);
        repeat (2) @(negedge mclk);
        chk("pins a on", 32'h0, {terminal_ready_n_ch_a, request_to_send_n_ch_a,
            aux_out2_n_ch_a, irq_out_oe_n_ch_a});
        chk("pins b", 32'hf, {terminal_ready_n_ch_b, request_to_send_n_ch_b,
            aux_out2_n_ch_b, irq_out_oe_n_ch_b});
        apb(dus_pkg::OFS_MCTRL, 1'h1, 32'h0);
        repeat (2) @(negedge mclk);
        chk("pins a off", 32'hf, {terminal_ready_n_ch_a, request_to_send_n_ch_a,
            aux_out2_n_ch_a, irq_out_oe_n_ch_a});
        apb(dus_pkg::MAP_END, 1'h0, 32'h0);
        chk("unmapped error", 32'h1, rerr);
    endtask
    task automatic t_modem;
        int pos [4] = '{dus_pkg::MS_CTS, dus_pkg::MS_DSR, dus_pkg::MS_CD, dus_pkg::MS_RI};
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            model_a.modem <= ~(4'h1 << i);
            repeat (2) @(posedge mclk);
            apb(dus_pkg::OFS_MSTAT, 1'h0, 32'h0);
            chk("modem status a", 32'h1 << pos[i], rdat);
            apb(B + dus_pkg::OFS_MSTAT, 1'h0, 32'h0);
            chk("modem status b", 32'h0, rdat);
        end
    endtask
    task automatic t_tx;
        logic [7:0] b;
        @(posedge mclk);
        model_a.modem <= 4'h0;
        apb(dus_pkg::OFS_DATA, 1'h1, 32'h41);
        model_a.grab(b);
        chk("tx byte a", 32'h41, b);
        repeat (2 * BC) @(posedge mclk);
        chk("tx idle a", 32'h1, serial_out_ch_a);
    endtask
    task automatic t_cts;
        logic [7:0] b;
        @(posedge mclk);
        model_a.modem <= 4'hf;
        apb(dus_pkg::OFS_FEAT, 1'h1, 32'h80);
        apb(dus_pkg::OFS_IEN, 1'h1, 32'h80);
        apb(dus_pkg::OFS_DATA, 1'h1, 32'ha5);
        repeat (3 * BC) @(posedge mclk);
        chk("cts hold a", 32'h1, serial_out_ch_a);
        model_a.modem <= 4'he;
        model_a.grab(b);
        chk("cts release a", 32'ha5, b);
    endtask
    task automatic t_rx_b;
        apb(B + dus_pkg::OFS_MCTRL, 1'h1, 32'h08);
        model_b.send(8'h5a);
        repeat (BC) @(negedge mclk);
        chk("rx ready b", 32'h0, rx_ready_n_ch_b);
        chk("irq masked b", 32'h0, irq_pin_b);
        chk("aux2 with irq b", 32'h0, aux_out2_n_ch_b);
        apb(B + dus_pkg::OFS_IMASK, 1'h1, 32'h1);
        repeat (2) @(negedge mclk);
        chk("irq raised b", 32'h1, irq_pin_b);
        apb(B + dus_pkg::OFS_ISTAT, 1'h1, 32'h1);
        repeat (2) @(negedge mclk);
        chk("irq cleared b", 32'h0, irq_pin_b);
        apb(B + dus_pkg::OFS_DATA, 1'h0, 32'h0);
        chk("rx byte b", 32'h5a, rdat);
        repeat (2) @(negedge mclk);
        chk("rx ready clear b", 32'h1, rx_ready_n_ch_b);
    endtask
    task automatic t_rts;
        apb(dus_pkg::OFS_MCTRL, 1'h1, 32'h0a);
        apb(dus_pkg::OFS_FEAT, 1'h1, 32'h40);
        apb(dus_pkg::OFS_IEN, 1'h1, 32'h40);
        apb(dus_pkg::OFS_IMASK, 1'h1, 32'h1);
        repeat (2) @(negedge mclk);
        chk("rts asserted a", 32'h0, request_to_send_n_ch_a);
        chk("irq idle a", 32'h0, irq_out_ch_a);
        model_a.send(8'h3c);
        repeat (BC) @(negedge mclk);
        chk("rts auto released a", 32'h1, request_to_send_n_ch_a);
        chk("irq level a", 32'h1, irq_out_ch_a);
        apb(dus_pkg::OFS_DATA, 1'h0, 32'h0);
        chk("rx byte a", 32'h3c, rdat);
        repeat (2) @(negedge mclk);
        chk("rts restored a", 32'h0, request_to_send_n_ch_a);
    endtask
    task automatic t_ir;
        int n;
        n = 0;
        apb(B + dus_pkg::OFS_MCTRL, 1'h1, 32'h40);
        repeat (2) @(negedge mclk);
        chk("ir idle b", 32'h0, serial_out_ch_b);
        apb(B + dus_pkg::OFS_DATA, 1'h1, 32'h0);
        repeat (12 * BC) begin
            @(posedge mclk);
            n += serial_out_ch_b;
        end
        chk("ir pulses b", 9 * (BC * dus_pkg::IR_PULSE_NUM / dus_pkg::IR_PULSE_DEN), n);
        model_b.send_ir(8'h96);
        repeat (BC) @(negedge mclk);
        apb(B + dus_pkg::OFS_DATA, 1'h0, 32'h0);
        chk("ir rx byte b", 32'h96, rdat);
    endtask
    task automatic test_done;
        if (bad_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 100);
        bad_count++;
        test_done;
    end
    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'h1;
        @(negedge mclk);
        t_reset;
        t_ctrl;
        t_modem;
        t_tx;
        t_cts;
        t_rx_b;
        t_rts;
        t_ir;
        test_done;
    end
endmodule
